// ### rtl/pmc_pkg.sv
package pmc_pkg;

    // ****************************************************************
    // Register map and field layout
    // ****************************************************************
    localparam logic [7:0] PMC_OFF_CTRL      = 8'h00;
    localparam logic [7:0] PMC_OFF_AUX       = 8'h04;
    localparam int         CTRL_IDLE_BIT     = 7;
    localparam int         CTRL_FREQ_HI      = 6;
    localparam int         CTRL_FREQ_LO      = 4;
    localparam int         CTRL_PRUN_BIT     = 3;
    localparam int         CTRL_ISTB_BIT     = 2;
    localparam int         CTRL_SCS_HI       = 1;
    localparam int         CTRL_SCS_LO       = 0;
    localparam int         AUX_SECEN_BIT     = 0;
    localparam int         AUX_SECUP_BIT     = 1;

    // ****************************************************************
    // Encodings and timing counts
    // ****************************************************************
    localparam logic [1:0] SRC_PRI           = 2'h0;
    localparam logic [1:0] SRC_SEC           = 2'h1;
    localparam logic [1:0] SRC_INT           = 2'h2;
    localparam logic [2:0] FREQ_FAST         = 3'h7;
    localparam logic [2:0] FREQ_SLOW         = 3'h0;
    localparam int         PAUSE_TICKS_DOC   = 8;
    localparam logic [1:0] RESP_OKAY         = 2'h0;
    localparam logic [1:0] RESP_SLVERR       = 2'h2;

    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b00,
        ST_PAUSE  = 2'b01,
        ST_SLEEP  = 2'b10
    } pmc_state_t;

    typedef struct packed {
        pmc_state_t  st;
        logic [1:0]  src;
        logic [1:0]  tgt;
        logic        idle_tgt;
        logic [3:0]  cnt;
        logic        cpu_en;
        logic        per_en;
        logic        want_pri;
        logic        wdt_rst;
        logic        idle;
        logic [2:0]  freq;
        logic [1:0]  scs;
        logic        sec_en;
        logic        prun;
        logic        istb;
        logic        secup;
        logic        fast_direct;
        logic        slow_sel;
        logic        awready;
        logic        aw_hold;
        logic [7:0]  awaddr;
        logic        wready;
        logic        w_hold;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } pmc_regs_t;

    // Frequency field resets to 000, so the slow select starts set
    localparam pmc_regs_t PMC_REGS_RST = '{
        st      : ST_ACTIVE,
        slow_sel: 1'b1,
        cpu_en  : 1'b1,
        per_en  : 1'b1,
        default : '0
    };

endpackage

// ### rtl/pmc_clock_modes.sv
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
// Overview of operation
// - Idle select decides CPU clocking, source select picks the clock source.
// - Source select 1x internal block, 01 secondary, 00 primary.
// - A new source select takes effect only at the power-down instruction.
// - Frequency code 111 fast direct, 110..001 divided, 000 slow source.
// - Sleep stops every clock, CPU and peripherals alike.
// - Run modes clock CPU and peripherals from the selected source.
// - Idle modes stop the CPU clock, peripherals stay clocked.
// - Power-down stops clocks next cycle, then counts eight new-source ticks.
// - Switch pause lasts seven to eight periods of the new clock.
// - Interrupt, reset or watchdog time-out returns to primary run.
// - A run mode may go to Sleep or same-source idle on power-down.
// - Outside primary run at most one source-status bit is set.
// - Primary running bit set only after start-up timer, primary supplying.
// - Internal stable bit set when stable fast source supplies the clock.
// - Secondary active bit set while secondary supplies the clock.
// - Slow source or unsettled fast source leaves all status bits clear.
// - Primary-internal config may show two bits; internal mode clears primary bit.
// - Power-down is a trigger for the selected mode, not plain Sleep.
// - Status bits read-only; power-on primary bit follows two-speed setting.
// - Watchdog wakes from idle, but resets the device in run modes.
// - Waking from idle runs the matching run mode until primary is ready.
module pmc_clock_modes
    import pmc_pkg::*;
#(
    parameter int PAUSE_TICKS = PAUSE_TICKS_DOC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [7:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    input  wire logic        sleep_exec,
    input  wire logic        wake_irq,
    input  wire logic        wdt_timeout,
    input  wire logic        pri_tick,
    input  wire logic        sec_tick,
    input  wire logic        int_tick,
    input  wire logic        primary_ready,
    input  wire logic        fast_osc_stable,
    input  wire logic        two_speed_startup_cfg,
    input  wire logic        primary_is_internal,
    output logic             cpu_clk_en,
    output logic             periph_clk_en,
    output logic [1:0]       clk_src_sel,
    output logic [2:0]       int_freq_sel,
    output logic             int_fast_direct,
    output logic             int_slow_sel,
    output logic             wdt_reset,
    output logic             primary_clock_running,
    output logic             internal_osc_stable,
    output logic             secondary_osc_active
);

    // ****************************************************************
    // Parameter check
    // ****************************************************************
    if (PAUSE_TICKS < 1 || PAUSE_TICKS > 15) begin : g_bad_pause
        $error("PAUSE_TICKS must lie in 1..15");
    end

    localparam logic [3:0] LAST_TICK = 4'(PAUSE_TICKS - 1);

    pmc_regs_t r;
    pmc_regs_t n;
    logic      tgt_tick;
    logic      wake_any;
    logic [1:0] sel_src;

    assign tgt_tick = (r.tgt == SRC_PRI) ? pri_tick :
                      (r.tgt == SRC_SEC) ? sec_tick : int_tick;
    assign wake_any = wake_irq | wdt_timeout;
    assign sel_src  = r.scs[CTRL_SCS_HI] ? SRC_INT : r.scs;

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        n         = r;
        n.wdt_rst = 1'b0;

        // Write address and data are taken independently
        if (r.awready && s_awvalid) begin
            n.aw_hold = 1'b1;
            n.awaddr  = s_awaddr;
        end
        if (r.wready && s_wvalid) begin
            n.w_hold = 1'b1;
            n.wdata  = s_wdata;
            n.wstrb  = s_wstrb;
        end
        if (r.bvalid && s_bready) begin
            n.bvalid = 1'b0;
        end
        if (n.aw_hold && n.w_hold && !n.bvalid) begin
            n.aw_hold = 1'b0;
            n.w_hold  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = RESP_OKAY;
            case (n.awaddr[7:2])
                PMC_OFF_CTRL[7:2]: begin
                    if (n.wstrb[0]) begin
                        n.idle = n.wdata[CTRL_IDLE_BIT];
                        n.freq = n.wdata[CTRL_FREQ_HI:CTRL_FREQ_LO];
                        n.scs  = n.wdata[CTRL_SCS_HI:CTRL_SCS_LO];
                    end
                end
                PMC_OFF_AUX[7:2]: begin
                    if (n.wstrb[0]) begin
                        n.sec_en = n.wdata[AUX_SECEN_BIT];
                    end
                end
                default: begin
                    n.bresp = RESP_SLVERR;
                end
            endcase
        end
        // Bit 0 cannot stand while the secondary is off
        if (!n.sec_en) begin
            n.scs[CTRL_SCS_LO] = 1'b0;
        end
        n.awready = !n.aw_hold && !n.bvalid;
        n.wready  = !n.w_hold && !n.bvalid;

        // Single read in flight; data sampled at address acceptance
        if (r.rvalid && s_rready) begin
            n.rvalid = 1'b0;
        end
        if (r.arready && s_arvalid) begin
            n.rvalid = 1'b1;
            n.rresp  = RESP_OKAY;
            n.rdata  = '0;
            case (s_araddr[7:2])
                PMC_OFF_CTRL[7:2]: begin
                    n.rdata[CTRL_IDLE_BIT]              = r.idle;
                    n.rdata[CTRL_FREQ_HI:CTRL_FREQ_LO]  = r.freq;
                    n.rdata[CTRL_PRUN_BIT]              = r.prun;
                    n.rdata[CTRL_ISTB_BIT]              = r.istb;
                    n.rdata[CTRL_SCS_HI:CTRL_SCS_LO]    = r.scs;
                end
                PMC_OFF_AUX[7:2]: begin
                    n.rdata[AUX_SECEN_BIT] = r.sec_en;
                    n.rdata[AUX_SECUP_BIT] = r.secup;
                end
                default: begin
                    n.rresp = RESP_SLVERR;
                end
            endcase
        end
        n.arready = !n.rvalid;

        // ------------------------------------------------------------
        // Mode sequencer
        // ------------------------------------------------------------
        case (r.st)
            ST_ACTIVE: begin
                if (r.want_pri && primary_ready) begin
                    // Primary ready: switch back, control bits untouched
                    n.st       = ST_PAUSE;
                    n.tgt      = SRC_PRI;
                    n.idle_tgt = 1'b0;
                    n.cnt      = '0;
                    n.cpu_en   = 1'b0;
                    n.per_en   = 1'b0;
                    n.want_pri = 1'b0;
                end else if (!r.cpu_en && wake_any) begin
                    // CPU resumes on the idle source first
                    n.cpu_en   = 1'b1;
                    n.want_pri = (r.src != SRC_PRI);
                end else if (r.cpu_en && wdt_timeout) begin
                    // Watchdog in a run mode resets
                    n.wdt_rst = 1'b1;
                end else if (r.cpu_en && wake_irq && r.src != SRC_PRI) begin
                    // Interrupt leaves a run mode for primary
                    n.want_pri = 1'b1;
                end else if (r.cpu_en && sleep_exec) begin
                    // Mode comes from the control bits
                    if (!r.idle && r.scs == SRC_PRI) begin
                        n.st     = ST_SLEEP;
                        n.cpu_en = 1'b0;
                        n.per_en = 1'b0;
                    end else if (sel_src == r.src) begin
                        // Same source: no switch, only CPU gate
                        n.cpu_en = !r.idle;
                    end else begin
                        // Clocks stop on the next cycle
                        n.st       = ST_PAUSE;
                        n.tgt      = sel_src;
                        n.idle_tgt = r.idle;
                        n.cnt      = '0;
                        n.cpu_en   = 1'b0;
                        n.per_en   = 1'b0;
                    end
                end
            end
            ST_PAUSE: begin
                // Tick phase is free, so 7 to 8 periods elapse
                if (tgt_tick) begin
                    if (r.cnt == LAST_TICK) begin
                        n.st     = ST_ACTIVE;
                        n.src    = r.tgt;
                        n.per_en = 1'b1;
                        n.cpu_en = !r.idle_tgt;
                    end else begin
                        n.cnt = r.cnt + 4'h1;
                    end
                end
            end
            ST_SLEEP: begin
                // Sleep always wakes to primary run
                if (wake_any) begin
                    n.st       = ST_PAUSE;
                    n.tgt      = SRC_PRI;
                    n.idle_tgt = 1'b0;
                    n.cnt      = '0;
                end
            end
            default: begin
                n.st = ST_ACTIVE;
            end
        endcase

        n.fast_direct = (n.freq == FREQ_FAST);
        n.slow_sel    = (n.freq == FREQ_SLOW);

        // ------------------------------------------------------------
        // Source status, only while a source really clocks
        // ------------------------------------------------------------
        // Primary bit waits for the start-up timer
        // Without two-speed start the primary is ready at power-on
        n.prun  = (n.st == ST_ACTIVE) && (n.src == SRC_PRI) &&
                  (primary_ready || !two_speed_startup_cfg);
        n.istb  = (n.st == ST_ACTIVE) && fast_osc_stable &&
                  ((n.src == SRC_INT && !n.slow_sel) ||
                   (n.src == SRC_PRI && primary_is_internal));
        n.secup = (n.st == ST_ACTIVE) && (n.src == SRC_SEC);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= PMC_REGS_RST;
        end else begin
            r <= n;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign s_awready             = r.awready;
    assign s_wready              = r.wready;
    assign s_bvalid              = r.bvalid;
    assign s_bresp               = r.bresp;
    assign s_arready             = r.arready;
    assign s_rvalid              = r.rvalid;
    assign s_rdata               = r.rdata;
    assign s_rresp               = r.rresp;
    assign cpu_clk_en            = r.cpu_en;
    assign periph_clk_en         = r.per_en;
    assign clk_src_sel           = r.src;
    assign int_freq_sel          = r.freq;
    assign int_fast_direct       = r.fast_direct;
    assign int_slow_sel          = r.slow_sel;
    assign wdt_reset             = r.wdt_rst;
    assign primary_clock_running = r.prun;
    assign internal_osc_stable   = r.istb;
    assign secondary_osc_active  = r.secup;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_SLEEP_DARK: assert property (
        r.st == ST_SLEEP |-> !cpu_clk_en && !periph_clk_en
    ) else $error("clock enabled in sleep");

    AST_SLEEP_ENTRY: assert property (
        r.st == ST_ACTIVE && cpu_clk_en && sleep_exec && !r.want_pri &&
        !wake_irq && !wdt_timeout && !r.idle && r.scs == SRC_PRI
        |=> r.st == ST_SLEEP
    ) else $error("power-down with 00 did not sleep");

    AST_PAUSE_GATED: assert property (
        r.st == ST_PAUSE |-> !cpu_clk_en && !periph_clk_en
    ) else $error("clock enabled during switch pause");

    AST_PAUSE_END: assert property (
        r.st == ST_PAUSE && tgt_tick && r.cnt == LAST_TICK
        |=> r.st == ST_ACTIVE && clk_src_sel == $past(r.tgt) && periph_clk_en
    ) else $error("pause did not end on last tick");

    AST_PAUSE_HOLD: assert property (
        r.st == ST_PAUSE && r.cnt != LAST_TICK |=> r.st == ST_PAUSE
    ) else $error("pause ended early");

    AST_SCS_NO_EFFECT: assert property (
        r.st == ST_ACTIVE && !sleep_exec && !r.want_pri && !wake_any
        |=> $stable(clk_src_sel) && r.st == ST_ACTIVE
    ) else $error("source changed without power-down");

    AST_SEC_BLOCK: assert property (
        !r.sec_en |-> !r.scs[CTRL_SCS_LO]
    ) else $error("select bit 0 set with secondary off");

    AST_STATUS_ONE: assert property (
        !primary_is_internal && !(cpu_clk_en && clk_src_sel == SRC_PRI)
        |-> $countones({primary_clock_running, internal_osc_stable,
                        secondary_osc_active}) <= 1
    ) else $error("more than one source status bit");

    AST_SEC_ACTIVE: assert property (
        secondary_osc_active == (r.st == ST_ACTIVE && clk_src_sel == SRC_SEC)
    ) else $error("secondary active bit wrong");

    AST_WDT_RUN: assert property (
        r.st == ST_ACTIVE && cpu_clk_en && wdt_timeout && !r.want_pri
        |=> wdt_reset ##1 !wdt_reset
    ) else $error("watchdog in run mode did not reset");

    AST_IDLE_WAKE: assert property (
        r.st == ST_ACTIVE && !cpu_clk_en && wake_any && !r.want_pri
        |=> cpu_clk_en && $stable(clk_src_sel) && $stable(r.scs)
    ) else $error("idle wake did not run on same source");

    AST_SLEEP_WAKE: assert property (
        r.st == ST_SLEEP && wake_any |=> r.st == ST_PAUSE && r.tgt == SRC_PRI
    ) else $error("sleep wake not toward primary");

    AST_IDLE_ENTRY: assert property (
        r.st == ST_ACTIVE && cpu_clk_en && sleep_exec && !r.want_pri && !wake_any &&
        r.idle && sel_src == clk_src_sel
        |=> !cpu_clk_en && periph_clk_en
    ) else $error("same-source idle entry wrong");

    AST_PAUSE_START: assert property (
        r.st == ST_ACTIVE && cpu_clk_en && sleep_exec && !r.want_pri && !wake_any &&
        sel_src != clk_src_sel && (r.idle || r.scs != SRC_PRI)
        |=> r.st == ST_PAUSE && r.tgt == $past(sel_src) && !cpu_clk_en
    ) else $error("switch pause not started");

    AST_START_TIMER: assert property (
        two_speed_startup_cfg && !primary_ready |=> !primary_clock_running
    ) else $error("primary bit set before start-up timer");

    AST_FREQ_DECODE: assert property (
        int_fast_direct == (int_freq_sel == FREQ_FAST) &&
        int_slow_sel == (int_freq_sel == FREQ_SLOW)
    ) else $error("frequency decode wrong");

endmodule

// ### test/pmc_osc_model.sv
`timescale 1ns/10ps
// ****************************************************************
// Oscillator sources and start-up timer seen by the mode block
// ****************************************************************
module pmc_osc_model #(
    parameter int START_CYC = 40
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic restart,
    output logic      pri_tick,
    output logic      sec_tick,
    output logic      int_tick,
    output logic      primary_ready,
    output logic      fast_osc_stable
);
    logic [7:0] ph_r;
    logic [7:0] su_r;

    // Periods 3, 7 and 2 keep the sources out of step with each other
    always_ff @(posedge aclk) begin
        if (!aresetn || restart) begin
            su_r <= 8'h00;
        end else if (su_r != 8'hFF) begin
            su_r <= su_r + 8'h01;
        end
        ph_r <= aresetn ? ph_r + 8'h01 : 8'h00;
        pri_tick <= aresetn && (ph_r % 3 == 0);
        sec_tick <= aresetn && (ph_r % 7 == 0);
        int_tick <= aresetn && ph_r[0];
        primary_ready <= aresetn && !restart && (su_r >= START_CYC);
        fast_osc_stable <= aresetn && (fast_osc_stable || ph_r > 8'h10);
    end
endmodule

// ### test/power_managed_clock_modes_test.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD %s exp %0h got %0h", n, e, g); end end
module power_managed_clock_modes_test
    import pmc_pkg::*;
;
    localparam int PT = PAUSE_TICKS_DOC;
    int          miscompares = 0;
    int          tests_run = 0;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r, src;
    logic [31:0] rdata, q, d;
    logic [2:0]  ev = 3'h0;
    logic        restart = 1'b0;
    logic        two_speed = 1'b1;
    logic        pri_int = 1'b0;
    logic        pri_tick, sec_tick, int_tick, pready, fstable;
    logic        cpu_en, per_en, fdir, fslow, wrst, prun, istb, t1r;
    logic [2:0]  freq;

    pmc_osc_model pmc_osc_model_inst (.aclk(aclk), .aresetn(aresetn), .restart(restart),
        .pri_tick(pri_tick), .sec_tick(sec_tick), .int_tick(int_tick),
        .primary_ready(pready), .fast_osc_stable(fstable));

    pmc_clock_modes #(.PAUSE_TICKS(PT)) pmc_clock_modes_inst (.aclk(aclk), .aresetn(aresetn),
        .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
        .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp),
        .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
        .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
        .s_rready(rready), .sleep_exec(ev[0]), .wake_irq(ev[1]), .wdt_timeout(ev[2]),
        .pri_tick(pri_tick), .sec_tick(sec_tick), .int_tick(int_tick),
        .primary_ready(pready), .fast_osc_stable(fstable),
        .two_speed_startup_cfg(two_speed), .primary_is_internal(pri_int),
        .cpu_clk_en(cpu_en), .periph_clk_en(per_en), .clk_src_sel(src),
        .int_freq_sel(freq), .int_fast_direct(fdir), .int_slow_sel(fslow),
        .wdt_reset(wrst), .primary_clock_running(prun), .internal_osc_stable(istb),
        .secondary_osc_active(t1r));

    initial begin
        forever #12.5 aclk = ~aclk;
    end

    // ****************************************************************
    // Bus master and event helpers
    // ****************************************************************
    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        fork
            begin
                do @(posedge aclk); while (!awready);
                awvalid <= 1'b0;
            end
            begin
                do @(posedge aclk); while (!wready);
                wvalid <= 1'b0;
            end
        join
        while (!bvalid) @(posedge aclk);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge aclk);
        r = rresp;
        q = rdata;
        rready <= 1'b0;
    endtask

    // One-cycle event: bit 0 power-down, bit 1 interrupt, bit 2 watchdog
    task automatic pulse(input logic [2:0] m);
        @(posedge aclk);
        ev <= m;
        @(posedge aclk);
        ev <= 3'h0;
        @(negedge aclk);
    endtask

    function automatic logic tk(input logic [1:0] s);
        return (s == SRC_PRI) ? pri_tick : ((s == SRC_SEC) ? sec_tick : int_tick);
    endfunction

    // Counts new-source ticks seen while the system clocks are stopped
    task automatic settle(input logic [1:0] s);
        int n;
        n = 0;
        for (int i = 0; i < 100 && per_en; i++) @(negedge aclk);
        for (int i = 0; i < 300 && !per_en; i++) begin
            n += int'(tk(s));
            @(negedge aclk);
        end
        `CHK("pause ticks", PT, n)
        `CHK("new source", s, src)
    endtask

    task automatic go(input logic [7:0] c, input logic [1:0] s, input logic pz);
        axw(PMC_OFF_CTRL, {24'h0, c});
        pulse(3'b001);
        `CHK("cpu stopped", 1'b0, cpu_en)
        if (pz) begin
            `CHK("periph stopped", 1'b0, per_en)
            settle(s);
        end
        `CHK("source", s, src)
        `CHK("cpu clock", ~c[7], cpu_en)
        `CHK("periph clock", 1'b1, per_en)
    endtask

    task automatic back(input logic [2:0] m);
        pulse(m);
        settle(SRC_PRI);
        `CHK("primary run cpu", 1'b1, cpu_en)
    endtask

    task automatic conclude;
        if (miscompares == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #(25 * 40000);
        miscompares++;
        conclude;
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        void'($urandom(32'h6EEA));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        `CHK("reset enables", 2'b11, {cpu_en, per_en})
        `CHK("power-on status", 3'h0, {prun, istb, t1r})
        `CHK("reset slow select", 1'b1, fslow)
        axr(PMC_OFF_AUX);
        `CHK("aux reset", 32'h0, q)
        axr(8'h08);
        `CHK("unmapped read", {RESP_SLVERR, 32'h0}, {r, q})
        axw(8'h0C, 32'hFF);
        `CHK("unmapped write", RESP_SLVERR, r)
        repeat (45) @(negedge aclk);
        `CHK("primary running", 1'b1, prun)
        axw(PMC_OFF_CTRL, 32'h01);
        axr(PMC_OFF_CTRL);
        `CHK("select blocked", 32'h08, q)
        axw(PMC_OFF_AUX, 32'h01);
        for (int i = 0; i < 16; i++) begin
            d = $urandom;
            if (i < 8) d[6:4] = i[2:0];
            axw(PMC_OFF_CTRL, d);
            axr(PMC_OFF_CTRL);
            `CHK("ctrl readback", {24'h0, d[7:4], 2'b10, d[1:0]}, q)
            `CHK("source held", SRC_PRI, src)
            `CHK("freq", d[6:4], freq)
            `CHK("fast direct", d[6:4] == FREQ_FAST, fdir)
            `CHK("slow select", d[6:4] == FREQ_SLOW, fslow)
        end
        go(8'h01, SRC_SEC, 1'b1);
        `CHK("secondary status", 3'b001, {prun, istb, t1r})
        go(8'h81, SRC_SEC, 1'b0);
        `CHK("idle status", 3'b001, {prun, istb, t1r})
        @(posedge aclk);
        restart <= 1'b1;
        @(posedge aclk);
        restart <= 1'b0;
        pulse(3'b100);
        `CHK("idle wake cpu", 1'b1, cpu_en)
        `CHK("idle wake source", SRC_SEC, src)
        `CHK("no wdt reset", 1'b0, wrst)
        settle(SRC_PRI);
        axr(PMC_OFF_CTRL);
        `CHK("bits kept", 32'h89, q)
        go(8'h72, SRC_INT, 1'b1);
        `CHK("fast status", 3'b010, {prun, istb, t1r})
        back(3'b010);
        go(8'h02, SRC_INT, 1'b1);
        `CHK("slow status", 3'b000, {prun, istb, t1r})
        back(3'b010);
        axw(PMC_OFF_CTRL, 32'h00);
        pulse(3'b001);
        `CHK("sleep", 2'b00, {cpu_en, per_en})
        repeat (20) @(negedge aclk);
        `CHK("sleep held", 5'h00, {cpu_en, per_en, prun, istb, t1r})
        back(3'b010);
        pulse(3'b100);
        `CHK("wdt reset", 1'b1, wrst)
        @(negedge aclk);
        `CHK("wdt no mode change", {1'b0, 1'b1, SRC_PRI}, {wrst, cpu_en, src})
        go(8'h80, SRC_PRI, 1'b0);
        pulse(3'b010);
        `CHK("primary idle wake", 2'b11, {cpu_en, per_en})
        @(posedge aclk);
        pri_int <= 1'b1;
        repeat (2) @(negedge aclk);
        `CHK("internal primary", 3'b110, {prun, istb, t1r})
        go(8'h72, SRC_INT, 1'b1);
        `CHK("internal mode", 3'b010, {prun, istb, t1r})
        back(3'b010);
        @(posedge aclk);
        pri_int <= 1'b0;
        two_speed <= 1'b0;
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(negedge aclk);
        `CHK("two-speed off", 4'b0100, {pready, prun, istb, t1r})
        axr(PMC_OFF_CTRL);
        `CHK("control after reset", 32'h08, q)
        conclude;
    end
endmodule
